// *** common/spim_map.svh ***
// offsets, field positions, reset values and divider counts of the spi port
`ifndef SPIM_MAP_SVH
`define SPIM_MAP_SVH

// ============================================================
// register offsets
`define SPIM_ADDR_MODE    2'h0
`define SPIM_ADDR_LINE    2'h1
`define SPIM_ADDR_DATA    2'h2

// ============================================================
// mode control fields
`define SPIM_MC_ICF       0
`define SPIM_MC_EN        1
`define SPIM_MC_UMD       4
`define SPIM_MC_MODE_LSB  5
`define SPIM_MC_MODE_MSB  7

// ============================================================
// line control fields
`define SPIM_LC_TRF       0
`define SPIM_LC_WRITE_COLLISION_FLAG      1
`define SPIM_LC_SELECT_PIN_ENABLE      2
`define SPIM_LC_MLS       3
`define SPIM_LC_CAPTURE_EDGE_SELECT      4
`define SPIM_LC_CLOCK_IDLE_POLARITY    5

// ============================================================
// reset values
`define SPIM_RST_MODE     8'he0
`define SPIM_RST_LINE     8'h00
`define SPIM_RST_DATA     8'h00

// ============================================================
// operating mode codes
`define SPIM_MODE_DIV4    3'h0
`define SPIM_MODE_DIV16   3'h1
`define SPIM_MODE_DIV64   3'h2
`define SPIM_MODE_SUB     3'h3
`define SPIM_MODE_TMR     3'h4
`define SPIM_MODE_SLAVE   3'h5

// ============================================================
// system clocks per half serial clock period, then last half, last bit and bits per byte
`define SPIM_HALF_DIV4    6'd2
`define SPIM_HALF_DIV16   6'd8
`define SPIM_HALF_DIV64   6'd32
`define SPIM_LAST_HALF    4'd15
`define SPIM_LAST_BIT     4'd7
`define SPIM_BYTE_BITS    4'd8

`endif

// *** common/spim_pkg.sv ***
// types shared by the spi port modules
package spim_pkg;

    typedef enum logic [0:0]
    {
        ST_IDLE  = 1'b0,
        ST_SHIFT = 1'b1
    } spim_st_e;

    typedef struct packed
    {
        logic [7:0] mode_ctrl;
        logic [7:0] line_ctrl;
        logic [7:0] shreg;
        spim_st_e   st;
        logic [3:0] bit_cnt;
        logic [3:0] half_cnt;
        logic       pend;
        logic       samp;
        logic       sdo;
        logic       sck;
        logic [7:0] rdata;
    } spim_state_s;

    typedef struct packed
    {
        logic [5:0] cnt;
        logic       sub_prev;
    } spim_div_s;

    typedef struct packed
    {
        logic prev;
    } spim_edge_s;

endpackage

// *** hw/spim_clkgen.sv ***
// half-period tick generator for the master serial clock
`timescale 1ns/1ns
`include "spim_map.svh"
module spim_clkgen
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // control
    input  wire logic       run_i,
    input  wire logic [2:0] sel_i,
    // alternate sources
    input  wire logic       sub_clk_i,
    input  wire logic       tmr_match_i,
    // tick
    output logic            half_tick_o
);
    spim_pkg::spim_div_s s;
    spim_pkg::spim_div_s next_s;
    logic [5:0]          last;

    always_comb
    begin
        next_s = s;
        next_s.sub_prev = sub_clk_i;
        half_tick_o = 1'b0;
        if (sel_i == `SPIM_MODE_DIV4)
            last = `SPIM_HALF_DIV4 - 6'd1;
        else if (sel_i == `SPIM_MODE_DIV16)
            last = `SPIM_HALF_DIV16 - 6'd1;
        else
            last = `SPIM_HALF_DIV64 - 6'd1;
        if (!run_i)
            next_s.cnt = 6'd0;
        else if (sel_i == `SPIM_MODE_SUB)
            half_tick_o = sub_clk_i ^ s.sub_prev; // each sub edge: half period
        else if (sel_i == `SPIM_MODE_TMR)
            half_tick_o = tmr_match_i; // two matches per serial period
        else if (s.cnt == last)
        begin
            half_tick_o = 1'b1;
            next_s.cnt = 6'd0;
        end
        else
            next_s.cnt = s.cnt + 6'd1;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            s <= '0;
        else
            s <= next_s;
    end
endmodule // spim_clkgen

// *** hw/spim_edge.sv ***
// leading and trailing edge finder for the external serial clock
`timescale 1ns/1ns
module spim_edge
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // serial clock
    input  wire logic en_i,
    input  wire logic sck_i,
    input  wire logic idle_hi_i,
    // events
    output logic      lead_o,
    output logic      trail_o
);
    spim_pkg::spim_edge_s s;
    spim_pkg::spim_edge_s next_s;
    logic                 chg;

    always_comb
    begin
        next_s.prev = sck_i;
        chg = en_i & (s.prev ^ sck_i);
        lead_o = chg & (sck_i != idle_hi_i);
        trail_o = chg & (sck_i == idle_hi_i);
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            s.prev <= 1'b1; // matches the idle-high default, no false edge
        else
            s <= next_s;
    end
endmodule // spim_edge

// *** hw/spim_top.sv ***
// four-line spi master/slave port with its register file
// ============================================================
// Function
// - modes 000/001/010: master, serial clock is system clock /4, /16, /64
// - 011 sub clock master, 100 timer match/2 master, 101 slave, others idle
// - interface enable low: lines released, engine held idle
// - slave deselected mid byte sets incomplete and done flags
// - software setting incomplete flag never sets done flag
// - idle polarity 0 keeps clock high, 1 keeps it low
// - capture edge follows polarity and edge bit table
// - order bit 1 sends msb first, 0 lsb first
// - select enable 0 ignores select pin, 1 uses it active low
// - data write during transfer dropped, collision flag set, software clears
// - done flag set at each completion, held until software clears it or the next byte starts
// - one 8-bit data register holds transmit and receive byte
// - master alone drives clock; slave uses external clock
// - line control and data reachable only in spi modes
// - byte shifts out while another shifts in
// - line control bits 7 and 6 are plain read/write storage
// - master data write while enabled starts transfer at once
// - enabled: data output high idle except a slave's first bit after a data write, master drives clock idle level
// - slave with select disabled is always active
`timescale 1ns/1ns
`include "spim_map.svh"
module spim_top
(
    // clock and reset
    input  wire logic       MCLK_I,
    input  wire logic       RST_N_I,
    // register port
    input  wire logic [1:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WE_I,
    input  wire logic       RE_I,
    output logic      [7:0] RDATA_O,
    // alternate master clock sources
    input  wire logic       SUB_CLK_I,
    input  wire logic       TMR_MATCH_I,
    // serial lines
    input  wire logic       SCK_I,
    output logic            SCK_O,
    output logic            SCK_OE_O,
    input  wire logic       SDI_I,
    output logic            SDO_O,
    output logic            SDO_OE_O,
    input  wire logic       SCS_N_I,
    // status
    output logic            XFER_DONE_O
);
    spim_pkg::spim_state_s s;
    spim_pkg::spim_state_s next_s;

    logic [2:0] mode;
    logic       spi_sel;
    logic       master;
    logic       slave;
    logic       en;
    logic       busy;
    logic       slave_act;
    logic       capture_edge_select;
    logic       msb;
    logic       select_pin_enable;
    logic       tick;
    logic       s_lead;
    logic       s_trail;
    logic       ev_lead;
    logic       ev_trail;
    logic       cap;
    logic       lau;
    logic       abort;
    logic       wr_data;

    function automatic logic out_bit(input logic [7:0] sh, input logic m);
        out_bit = m ? sh[7] : sh[0];
    endfunction

    function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b,
                                            input logic m);
        shift_in = m ? {sh[6:0], b} : {b, sh[7:1]};
    endfunction

    // ============================================================
    // decode
    always_comb
    begin
        mode = s.mode_ctrl[`SPIM_MC_MODE_MSB:`SPIM_MC_MODE_LSB];
        spi_sel = !s.mode_ctrl[`SPIM_MC_UMD] && (mode <= `SPIM_MODE_SLAVE);
        master = spi_sel && (mode < `SPIM_MODE_SLAVE);
        slave = spi_sel && (mode == `SPIM_MODE_SLAVE);
        en = s.mode_ctrl[`SPIM_MC_EN] && spi_sel;
        capture_edge_select = s.line_ctrl[`SPIM_LC_CAPTURE_EDGE_SELECT];
        msb = s.line_ctrl[`SPIM_LC_MLS];
        select_pin_enable = s.line_ctrl[`SPIM_LC_SELECT_PIN_ENABLE];
        busy = (s.st == spim_pkg::ST_SHIFT);
        slave_act = en && slave && (!select_pin_enable || !SCS_N_I);
        abort = en && slave && select_pin_enable && SCS_N_I && busy;
        ev_lead = master ? (tick && !s.half_cnt[0]) : s_lead;
        ev_trail = master ? (tick && s.half_cnt[0]) : s_trail;
        cap = capture_edge_select ? ev_lead : ev_trail;
        lau = capture_edge_select ? ev_trail : ev_lead;
        wr_data = WE_I && (ADDR_I == `SPIM_ADDR_DATA) && spi_sel;
    end

    // master clock only runs while a byte is moving
    spim_clkgen u_clkgen
    (
        .clk_i       (MCLK_I),
        .rst_n_i     (RST_N_I),
        .run_i       (en && master && busy),
        .sel_i       (mode),
        .sub_clk_i   (SUB_CLK_I),
        .tmr_match_i (TMR_MATCH_I),
        .half_tick_o (tick)
    );

    spim_edge u_edge
    (
        .clk_i     (MCLK_I),
        .rst_n_i   (RST_N_I),
        .en_i      (slave_act),
        .sck_i     (SCK_I),
        .idle_hi_i (!s.line_ctrl[`SPIM_LC_CLOCK_IDLE_POLARITY]),
        .lead_o    (s_lead),
        .trail_o   (s_trail)
    );

    // ============================================================
    // next state
    always_comb
    begin
        next_s = s;
        next_s.rdata = 8'h00;

        // reads answer the cycle after the strobe only
        if (RE_I)
        begin
            if (ADDR_I == `SPIM_ADDR_MODE)
                next_s.rdata = s.mode_ctrl;
            else if (ADDR_I == `SPIM_ADDR_LINE && spi_sel)
                next_s.rdata = s.line_ctrl;
            else if (ADDR_I == `SPIM_ADDR_DATA && spi_sel)
                next_s.rdata = s.shreg;
        end

        // software writes come first so hardware sets win
        if (WE_I && ADDR_I == `SPIM_ADDR_MODE)
            next_s.mode_ctrl = WDATA_I;
        if (WE_I && ADDR_I == `SPIM_ADDR_LINE && spi_sel)
            next_s.line_ctrl = WDATA_I;
        if (wr_data)
        begin
            if (busy)
                next_s.line_ctrl[`SPIM_LC_WRITE_COLLISION_FLAG] = 1'b1;
            else
            begin
                next_s.shreg = WDATA_I;
                next_s.sdo = out_bit(WDATA_I, msb);
                if (en && master)
                begin
                    next_s.st = spim_pkg::ST_SHIFT;
                    next_s.half_cnt = 4'd0;
                    next_s.bit_cnt = 4'd0;
                    next_s.pend = 1'b0;
                    next_s.line_ctrl[`SPIM_LC_TRF] = 1'b0;
                end
            end
        end

        // slave wakes only on a leading edge: the trailing edge after the
        // last capture, or a parked clock moving, must not open a new byte
        if (slave_act && !busy && ev_lead)
        begin
            next_s.st = spim_pkg::ST_SHIFT;
            next_s.bit_cnt = 4'd0;
            next_s.pend = 1'b0;
            next_s.line_ctrl[`SPIM_LC_TRF] = 1'b0;
        end

        // capture then launch, so the line never changes on its own sample edge
        if (busy || (slave_act && ev_lead))
        begin
            if (cap)
            begin
                if (s.bit_cnt == `SPIM_LAST_BIT)
                begin
                    next_s.shreg = shift_in(s.shreg, SDI_I, msb);
                    next_s.pend = 1'b0;
                end
                else
                begin
                    next_s.samp = SDI_I;
                    next_s.pend = 1'b1;
                end
                next_s.bit_cnt = s.bit_cnt + 4'd1;
            end
            else if (lau && s.pend)
            begin
                next_s.shreg = shift_in(s.shreg, s.samp, msb);
                next_s.sdo = out_bit(shift_in(s.shreg, s.samp, msb), msb);
                next_s.pend = 1'b0;
            end
        end

        // master edges and end of byte
        if (master && busy && tick)
        begin
            next_s.sck = !s.sck;
            next_s.half_cnt = s.half_cnt + 4'd1;
            if (s.half_cnt == `SPIM_LAST_HALF)
            begin
                next_s.st = spim_pkg::ST_IDLE;
                next_s.bit_cnt = 4'd0;
                next_s.sdo = 1'b1;
                next_s.line_ctrl[`SPIM_LC_TRF] = 1'b1;
            end
        end

        // slave ends on its eighth capture
        if (slave && next_s.bit_cnt == `SPIM_BYTE_BITS)
        begin
            next_s.st = spim_pkg::ST_IDLE;
            next_s.bit_cnt = 4'd0;
            next_s.sdo = 1'b1;
            next_s.line_ctrl[`SPIM_LC_TRF] = 1'b1;
        end

        if (abort)
        begin
            next_s.st = spim_pkg::ST_IDLE;
            next_s.bit_cnt = 4'd0;
            next_s.pend = 1'b0;
            next_s.sdo = 1'b1;
            next_s.mode_ctrl[`SPIM_MC_ICF] = 1'b1;
            next_s.line_ctrl[`SPIM_LC_TRF] = 1'b1;
        end

        // clock parks at its idle level outside a byte
        if (next_s.st == spim_pkg::ST_IDLE)
            next_s.sck = !next_s.line_ctrl[`SPIM_LC_CLOCK_IDLE_POLARITY];

        // disabled: engine frozen idle, register contents kept
        if (!en)
        begin
            next_s.st = spim_pkg::ST_IDLE;
            next_s.bit_cnt = 4'd0;
            next_s.pend = 1'b0;
            next_s.sdo = 1'b1;
        end
    end

    always_ff @(posedge MCLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            s <= '0;
            s.mode_ctrl <= `SPIM_RST_MODE;
            s.line_ctrl <= `SPIM_RST_LINE;
            s.shreg <= `SPIM_RST_DATA;
            s.sdo <= 1'b1;
            s.sck <= 1'b1;
        end
        else
            s <= next_s;
    end

    // ============================================================
    // outputs
    assign RDATA_O = s.rdata;
    assign SCK_O = s.sck;
    assign SCK_OE_O = en && master;
    assign SDO_O = s.sdo;
    assign SDO_OE_O = en;
    assign XFER_DONE_O = s.line_ctrl[`SPIM_LC_TRF];

    // ============================================================
    // checks
    chk_write_collision_flag_on_busy: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        wr_data && busy |=> s.line_ctrl[`SPIM_LC_WRITE_COLLISION_FLAG])
        else $error("collision not flagged");

    // a shift edge in the same cycle legally moves the register
    chk_write_collision_flag_keeps_data: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        wr_data && busy && !cap && !lau |=> $stable(s.shreg))
        else $error("colliding write overwrote data");

    chk_master_start: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        wr_data && !busy && en && master |=> busy && !XFER_DONE_O)
        else $error("master write did not start a byte");

    chk_done_at_end: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        busy && en && master ##1 !busy && $past(en) |-> XFER_DONE_O)
        else $error("done flag missing after master byte");

    chk_busy_no_done: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        busy && $past(busy) |-> !XFER_DONE_O)
        else $error("done flag high during transfer");

    chk_idle_level: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        !busy && $past(!busy) && !$past(WE_I) |-> SCK_O == !s.line_ctrl[`SPIM_LC_CLOCK_IDLE_POLARITY])
        else $error("serial clock off its idle level");

    chk_div4_rate: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        busy && mode == `SPIM_MODE_DIV4 && en && $changed(s.sck) && s.half_cnt != 4'd0
        |=> $stable(s.sck) ##1 $changed(s.sck))
        else $error("divide by four clock wrong");

    chk_abort_flags: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        abort |=> s.mode_ctrl[`SPIM_MC_ICF] && XFER_DONE_O && !busy)
        else $error("incomplete slave byte not flagged");

    chk_sw_icf: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        WE_I && ADDR_I == `SPIM_ADDR_MODE && WDATA_I[`SPIM_MC_ICF] && !busy && !XFER_DONE_O
        |=> !XFER_DONE_O)
        else $error("software incomplete flag set done flag");

    chk_off_released: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        !en |-> !SCK_OE_O && !SDO_OE_O ##1 !busy)
        else $error("lines driven while disabled");
endmodule // spim_top

// *** verification/spim_peer.sv ***
// behavioural far-side spi device: slave to our master, or master to our slave
`timescale 1ns/1ns
module spim_peer
(
    // clock
    input  wire logic       clk_i,
    // wire levels seen
    input  wire logic       sck_line_i,
    input  wire logic       sck_oe_i,
    input  wire logic       sdo_i,
    // link settings
    input  wire logic       idle_hi_i,
    input  wire logic       capture_edge_select_i,
    input  wire logic       msb_i,
    // driven lines
    output logic            sck_o,
    output logic            sdi_o,
    output logic            scs_n_o,
    output logic      [7:0] rx_o
);
    logic [7:0] sh;
    logic [3:0] cnt;
    logic       run;
    logic       lead;
    logic       sdo_q;

    // pre-edge copy: the design may move its data line in the clock's own step
    always @(negedge clk_i)
        sdo_q <= sdo_i;

    initial
    begin
        sck_o   = 1'b1;
        sdi_o   = 1'b0;
        scs_n_o = 1'b1;
        rx_o    = 8'h00;
        sh      = 8'h00;
        cnt     = 4'h0;
        run     = 1'b0;
    end

    // ============================================================
    // byte preparation
    task automatic arm(input logic [7:0] tx);
        cnt   = 4'h0;
        sck_o = idle_hi_i;
        sdi_o = msb_i ? tx[7] : tx[0];
        sh    = msb_i ? tx << 1 : tx >> 1;
    endtask

    // ============================================================
    // master role: clock only inside frames, 8 system clocks a half
    task automatic frame(input int edges, input logic use_sel);
        run = 1'b1;
        if (use_sel)
            scs_n_o = 1'b0;
        repeat (4) @(negedge clk_i);
        repeat (edges)
        begin
            sck_o = ~sck_o;
            repeat (8) @(negedge clk_i);
        end
        scs_n_o = 1'b1;
        run     = 1'b0;
    endtask

    // ============================================================
    // shift engine on each link clock edge while our master drives the clock or a frame runs
    always @(sck_line_i)
    begin
        if (sck_oe_i || run)
        begin
            lead = (sck_line_i !== idle_hi_i);
            if (lead == capture_edge_select_i)
            begin
                rx_o = msb_i ? {rx_o[6:0], sdo_q} : {sdo_q, rx_o[7:1]};
                cnt  = cnt + 4'h1;
            end
            else if (cnt != 4'h0 && cnt < 4'h8)
            begin
                sdi_o = msb_i ? sh[7] : sh[0];
                sh    = msb_i ? sh << 1 : sh >> 1;
            end
            else if (cnt == 4'h8)
                sdi_o = ~sdi_o; // hold time over, no stale bit
        end
    end
endmodule // spim_peer

// *** verification/testbench.sv ***
// self-checking bench of the spi port against the far-side model
`timescale 1ns/1ns
module testbench;
    logic       MCLK_I = 1'b0;
    logic       RST_N_I;
    logic [1:0] ADDR_I;
    logic [7:0] WDATA_I;
    logic       WE_I;
    logic       RE_I;
    logic [7:0] RDATA_O;
    logic       SUB_CLK_I = 1'b0;
    logic       TMR_MATCH_I = 1'b0;
    logic       SCK_I;
    logic       SCK_O;
    logic       SCK_OE_O;
    logic       SDI_I;
    logic       SDO_O;
    logic       SDO_OE_O;
    logic       SCS_N_I;
    logic       XFER_DONE_O;
    logic       peer_sck;
    logic       cfg_pol;
    logic       cfg_eg;
    logic       cfg_mls;
    logic       sck_q = 1'b1;
    logic [9:0] run_cnt = 10'h0;
    logic [9:0] gap = 10'h0;
    int         cyc = 0;
    int         failures = 0;
    int         checks_done = 0;
    // {mode, polarity, edge, order, half period}
    localparam logic [11:0] MTAB [6] = '{12'h0c2, 12'h102, 12'h248, 12'h5a0, 12'h6c3, 12'h985};

    always #25 MCLK_I = ~MCLK_I;
    assign SCK_I = SCK_OE_O ? SCK_O : peer_sck;

    spim_top DUT
    (
        .MCLK_I      (MCLK_I),
        .RST_N_I     (RST_N_I),
        .ADDR_I      (ADDR_I),
        .WDATA_I     (WDATA_I),
        .WE_I        (WE_I),
        .RE_I        (RE_I),
        .RDATA_O     (RDATA_O),
        .SUB_CLK_I   (SUB_CLK_I),
        .TMR_MATCH_I (TMR_MATCH_I),
        .SCK_I       (SCK_I),
        .SCK_O       (SCK_O),
        .SCK_OE_O    (SCK_OE_O),
        .SDI_I       (SDI_I),
        .SDO_O       (SDO_O),
        .SDO_OE_O    (SDO_OE_O),
        .SCS_N_I     (SCS_N_I),
        .XFER_DONE_O (XFER_DONE_O)
    );

    spim_peer peer
    (
        .clk_i      (MCLK_I),
        .sck_line_i (SCK_I),
        .sck_oe_i   (SCK_OE_O),
        .sdo_i      (SDO_O),
        .idle_hi_i  (~cfg_pol),
        .capture_edge_select_i     (cfg_eg),
        .msb_i      (cfg_mls),
        .sck_o      (peer_sck),
        .sdi_o      (SDI_I),
        .scs_n_o    (SCS_N_I),
        .rx_o       ()
    );

    // ============================================================
    // alternate clock sources and serial half period monitor
    always @(posedge MCLK_I)
    begin
        cyc         <= cyc + 1;
        SUB_CLK_I   <= (cyc % 6) < 3;
        TMR_MATCH_I <= (cyc % 5) == 0;
        sck_q       <= SCK_O;
        if (SCK_O !== sck_q)
        begin
            gap     <= run_cnt;
            run_cnt <= 10'h1;
        end
        else
            run_cnt <= run_cnt + 10'h1;
    end

    // ============================================================
    // access tasks
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge MCLK_I);
        ADDR_I  <= a;
        WDATA_I <= d;
        WE_I    <= 1'b1;
        @(posedge MCLK_I);
        WE_I    <= 1'b0;
    endtask

    task rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge MCLK_I);
        ADDR_I <= a;
        RE_I   <= 1'b1;
        @(posedge MCLK_I);
        RE_I   <= 1'b0;
        @(negedge MCLK_I);
        chk(RDATA_O, exp);
    endtask

    task wait_done;
        int n;
        n = 0;
        while (XFER_DONE_O !== 1'b1 && n < 2000)
        begin
            @(negedge MCLK_I);
            n++;
        end
        chk({7'h0, XFER_DONE_O}, 8'h01);
    endtask

    task run_master(input logic [11:0] e, input logic [7:0] dtx, input logic [7:0] ptx);
        logic [7:0] lc;
        cfg_pol = e[8];
        cfg_eg  = e[7];
        cfg_mls = e[6];
        lc      = {2'b00, e[8:6], 3'b000};
        wr(2'h0, {e[11:9], 5'h00});
        wr(2'h1, lc);
        wr(2'h0, {e[11:9], 5'h02});
        repeat (2) @(posedge MCLK_I);
        @(negedge MCLK_I);
        chk({7'h0, SCK_O}, {7'h0, ~e[8]});
        chk({5'h0, SCK_OE_O, SDO_O, SDO_OE_O}, 8'h07);
        peer.arm(ptx);
        wr(2'h2, dtx);
        wr(2'h2, ~dtx);
        @(negedge MCLK_I);
        chk({7'h0, XFER_DONE_O}, 8'h00);
        wait_done;
        rd(2'h1, lc | 8'h03);
        rd(2'h2, ptx);
        chk(peer.rx_o, dtx);
        chk(gap[7:0], {2'h0, e[5:0]});
        wr(2'h1, lc);
        @(negedge MCLK_I);
        chk({7'h0, XFER_DONE_O}, 8'h00);
    endtask

    task tally_and_finish;
        $display("checks %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ============================================================
    // main sequence
    initial
    begin
        RST_N_I = 1'b0;
        ADDR_I  = 2'h0;
        WDATA_I = 8'h00;
        WE_I    = 1'b0;
        RE_I    = 1'b0;
        cfg_pol = 1'b0;
        cfg_eg  = 1'b1;
        cfg_mls = 1'b1;
        repeat (3) @(posedge MCLK_I);
        RST_N_I <= 1'b1;
        rd(2'h0, 8'he0);
        rd(2'h1, 8'h00);
        rd(2'h3, 8'h00);
        wr(2'h0, 8'h10);
        wr(2'h1, 8'hc0);
        rd(2'h1, 8'h00);
        wr(2'h0, 8'h00);
        rd(2'h1, 8'h00);
        wr(2'h1, 8'hc0);
        rd(2'h1, 8'hc0);
        wr(2'h2, 8'h5a);
        repeat (40) @(posedge MCLK_I);
        @(negedge MCLK_I);
        chk({5'h0, XFER_DONE_O, SCK_OE_O, SDO_OE_O}, 8'h00);
        wr(2'h0, 8'h02);
        rd(2'h1, 8'hc0);
        for (int i = 0; i < 6; i++)
            run_master(MTAB[i], 8'h96 ^ 8'(i * 37), 8'h3c ^ 8'(i * 91));
        // slave: full byte, aborted byte, then select pin ignored
        cfg_pol = 1'b0;
        cfg_eg  = 1'b1;
        cfg_mls = 1'b1;
        wr(2'h0, 8'ha0);
        wr(2'h1, 8'h1c);
        wr(2'h0, 8'ha2);
        for (int k = 0; k < 3; k++)
        begin
            if (k == 2)
            begin
                {cfg_pol, cfg_eg, cfg_mls} = 3'b100;
                wr(2'h1, 8'h20);
            end
            @(negedge MCLK_I);
            chk({7'h0, SCK_OE_O}, 8'h00);
            peer.arm(8'h69 ^ 8'(k));
            wr(2'h2, 8'hc3 ^ 8'(k));
            peer.frame(k == 1 ? 6 : 16, k != 2);
            repeat (4) @(posedge MCLK_I);
            @(negedge MCLK_I);
            chk({7'h0, XFER_DONE_O}, 8'h01);
            rd(2'h0, k == 1 ? 8'ha3 : 8'ha2);
            if (k != 1)
            begin
                rd(2'h2, 8'h69 ^ 8'(k));
                chk(peer.rx_o, 8'hc3 ^ 8'(k));
            end
            wr(2'h1, k == 2 ? 8'h20 : 8'h1c);
            wr(2'h0, 8'ha2);
        end
        wr(2'h0, 8'ha3);
        @(negedge MCLK_I);
        chk({7'h0, XFER_DONE_O}, 8'h00);
        rd(2'h1, 8'h20);
        tally_and_finish;
    end

    // ============================================================
    // watchdog: expected run is under two thousand cycles
    initial
    begin
        #1000000;
        failures++;
        tally_and_finish;
    end
endmodule // testbench
